// >>> inc/lock_menu_defs.svh
// offsets, field positions, reset values and timing counts of the lock menu
`ifndef LOCK_MENU_DEFS_SVH
`define LOCK_MENU_DEFS_SVH

// register byte offsets
`define LOCK_OFF_CFG 4'h0
`define LOCK_OFF_CTRL 4'h4
`define LOCK_OFF_STAT 4'h8

// config register fields
`define LOCK_CFG_MODE_LSB 0
`define LOCK_CFG_ADDR_LSB 2
`define LOCK_CFG_TERM_BIT 5
// control register fields
`define LOCK_CTRL_OFFLONG_BIT 0
`define LOCK_CTRL_ERR_BIT 1

// defaults and address limits of the stored config
`define LOCK_DEF_MODE 2'h0
`define LOCK_DEF_ADDR 3'h1
`define LOCK_DEF_TERM 1'b0
`define LOCK_ADDR_MIN 3'h1
`define LOCK_ADDR_MAX 3'h4

// times in their own units
`define LOCK_CLK_HZ 10000000
`define LOCK_TICK_MS 500
`define LOCK_DEB_MS 20
`define LOCK_HOLD_MS 10000
`define LOCK_SHOW_MS 2000
`define LOCK_TERM_MS 1000
`define LOCK_UPTIME_MIN 20
`define LOCK_MENU_MIN 5

// counts of time-base ticks, least times rounded up, longest down
`define LOCK_HOLD_TICKS ((`LOCK_HOLD_MS + `LOCK_TICK_MS - 1) / `LOCK_TICK_MS)
`define LOCK_SHOW_TICKS (`LOCK_SHOW_MS / `LOCK_TICK_MS)
`define LOCK_TERM_TICKS (`LOCK_TERM_MS / `LOCK_TICK_MS)
`define LOCK_UP_TICKS (`LOCK_UPTIME_MIN * 60000 / `LOCK_TICK_MS)
`define LOCK_MENU_TICKS (`LOCK_MENU_MIN * 60000 / `LOCK_TICK_MS)

`endif

// >>> inc/lock_menu_pkg.sv
// types of the lock parameter menu
package lock_menu_pkg;

  typedef enum logic [1:0] {MODE_PROP, MODE_CAN, MODE_SOLO} mode_t;

  typedef enum logic [2:0] {
    LED_OFF, LED_BLUE, LED_YELLOW, LED_ORANGE, LED_GREEN, LED_RED
  } led_t;

  typedef struct packed {
    mode_t mode;
    logic [2:0] addr;
    logic term;
  } cfg_t;

  typedef enum logic [3:0] {
    ST_SHOW_MODE, ST_SHOW_ADDR, ST_SHOW_TERM, ST_IDLE,
    ST_SEL_MODE, ST_SEL_ADDR, ST_SEL_TERM, ST_SAVED, ST_ABORT
  } state_t;

endpackage

// >>> verilog/lock_parameter_menu_fsm.sv
// parameter menu state machine of the door lock
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lock_menu_defs.svh"

// Behaviour
// (RL1) idle open door shows stored mode colour
// (RL2) bus address limited to one through four
// (RL3) defaults: proprietary bus, address one, off
// (RL4) power-up shows mode colour two seconds
// (RL5) bus modes then flash address count green
// (RL6) CAN: one second green if terminated
// (RL7) menu entry needs off-time, uptime, no error
// (RL8) ten-second key hold starts or saves
// (RL9) brief key turn advances selection stage
// (RL10) handle press steps value, wrapping round
// (RL11) operator opens door, releases handle first
// (RL12) mode stage flashes candidate mode colour
// (RL13) address burst repeats after two seconds
// (RL14) CAN termination stage, green on, red off
// (RL15) save stores, green two seconds, colour
// (RL16) stand-alone saves straight from mode stage
// (RL17) brief turns return to mode selection
// (RL18) five-minute timeout: red, keep old config
// (RL19) power loss drops unsaved selections
// (RL20) switches debounced; early release is brief
module lock_parameter_menu_fsm #(
  parameter int TICK_CYCLES = `LOCK_CLK_HZ / 1000 * `LOCK_TICK_MS, // 0.5 s time base
  parameter int DEB_CYCLES = `LOCK_CLK_HZ / 1000 * `LOCK_DEB_MS // switch settle time
) (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rstn, // power-on reset
  input wire logic doorOpen, // door contact, high when open
  input wire logic keyUnlock, // key at unlock end stop
  input wire logic handleDown, // handle pressed
  input wire logic [3:0] regAddr, // register byte address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  output lock_menu_pkg::led_t led, // status led colour
  output lock_menu_pkg::cfg_t cfg, // stored configuration
  output logic saveStrobe // pulse: write cfg to storage
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DW = $clog2(DEB_CYCLES + 1);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  // time base

  logic [TW-1:0] tickCnt;
  logic tick;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt <= TW'(1); // first period one clock shorter than the rest
      tick <= 1'b0;
    end
    else
    begin
      tick <= (tickCnt == TW'(TICK_CYCLES - 1));
      tickCnt <= (tickCnt == TW'(TICK_CYCLES - 1)) ? '0 : tickCnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch debounce

  wire logic [1:0] rawIn;
  wire logic [1:0] swLvl;
  assign rawIn = {handleDown, keyUnlock};

  for (genvar i = 0; i < 2; i++)
  begin : g_deb
    logic smp;
    logic lvl;
    logic [DW-1:0] cnt;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        smp <= 1'b0;
        lvl <= 1'b0;
        cnt <= '0;
      end
      else
      begin
        smp <= rawIn[i];
        if (smp == lvl)
          cnt <= '0; // RL20
        else if (cnt == DW'(DEB_CYCLES - 1))
        begin
          cnt <= '0;
          lvl <= smp; // RL20
        end
        else
          cnt <= cnt + 1'b1;
      end
    end
    assign swLvl[i] = lvl;
  end

  ////////////////////////////////////////////////////////////////////////
  // key and handle events

  logic keyPrev;
  logic handlePrev;
  logic longDone;
  logic [4:0] holdTicks;
  wire logic keyLvl;
  wire logic handleLvl;
  wire logic handleEvt;
  wire logic longEvt;
  wire logic briefEvt;

  assign keyLvl = swLvl[0];
  assign handleLvl = swLvl[1];
  assign handleEvt = handleLvl && !handlePrev; // RL10
  // one extra tick so a hold of a whole 10 s is guaranteed
  assign longEvt = keyLvl && !longDone && tick
    && holdTicks == 5'(`LOCK_HOLD_TICKS); // RL8
  assign briefEvt = !keyLvl && keyPrev && !longDone; // RL20 RL9

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      keyPrev <= 1'b0;
      handlePrev <= 1'b0;
      longDone <= 1'b0;
      holdTicks <= '0;
    end
    else
    begin
      keyPrev <= keyLvl;
      handlePrev <= handleLvl;
      if (!keyLvl)
      begin
        holdTicks <= '0;
        longDone <= 1'b0;
      end
      else
      begin
        if (tick && !longDone)
          holdTicks <= holdTicks + 5'h1;
        if (longEvt)
          longDone <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // uptime, menu timeout and control bits

  lock_menu_pkg::state_t state;
  lock_menu_pkg::state_t next_state;
  lock_menu_pkg::cfg_t cand;
  lock_menu_pkg::cfg_t next_cand;
  logic [11:0] upTicks;
  logic [9:0] menuTicks;
  logic offLong;
  logic errShown;
  logic [3:0] ph;
  wire logic inMenu;
  wire logic allowed;
  wire logic timeout;

  assign inMenu = state == lock_menu_pkg::ST_SEL_MODE || state == lock_menu_pkg::ST_SEL_ADDR
    || state == lock_menu_pkg::ST_SEL_TERM;
  assign allowed = offLong && !errShown && doorOpen
    && upTicks < 12'(`LOCK_UP_TICKS); // RL7
  assign timeout = inMenu && menuTicks >= 10'(`LOCK_MENU_TICKS); // RL18

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      upTicks <= '0;
      menuTicks <= '0;
    end
    else
    begin
      if (tick && upTicks < 12'(`LOCK_UP_TICKS))
        upTicks <= upTicks + 12'h1; // RL7
      if (!inMenu)
        menuTicks <= '0;
      else if (tick)
        menuTicks <= menuTicks + 10'h1; // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port

  wire logic cfgSel;
  wire logic ctrlSel;
  wire logic statSel;
  wire logic cfgWrOk;
  wire logic [7:0] next_rdata;

  assign cfgSel = regAddr == `LOCK_OFF_CFG;
  assign ctrlSel = regAddr == `LOCK_OFF_CTRL;
  assign statSel = regAddr == `LOCK_OFF_STAT;
  // restore from storage only outside the menu, and only legal values
  assign cfgWrOk = regWr && cfgSel && !inMenu
    && regWdata[`LOCK_CFG_MODE_LSB+:2] != 2'h3
    && regWdata[`LOCK_CFG_ADDR_LSB+:3] >= `LOCK_ADDR_MIN
    && regWdata[`LOCK_CFG_ADDR_LSB+:3] <= `LOCK_ADDR_MAX; // RL2
  assign next_rdata = cfgSel ? {2'h0, cfg.term, cfg.addr, cfg.mode}
    : ctrlSel ? {6'h0, errShown, offLong}
    : statSel ? {2'h0, allowed, inMenu, state}
    : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdata <= 8'h00;
      offLong <= 1'b0;
      errShown <= 1'b0;
    end
    else
    begin
      regRdata <= regRd ? next_rdata : 8'h00;
      if (regWr && ctrlSel)
      begin
        offLong <= regWdata[`LOCK_CTRL_OFFLONG_BIT];
        errShown <= regWdata[`LOCK_CTRL_ERR_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // menu state machine

  logic save;
  wire logic [3:0] addrFlash;
  wire logic [2:0] addrStep;
  wire lock_menu_pkg::mode_t modeStep;

  assign addrFlash = {cfg.addr, 1'b0} - 4'h1;
  assign addrStep = cand.addr == `LOCK_ADDR_MAX ? `LOCK_ADDR_MIN : cand.addr + 3'h1; // RL10
  assign modeStep = cand.mode == lock_menu_pkg::MODE_PROP ? lock_menu_pkg::MODE_CAN
    : cand.mode == lock_menu_pkg::MODE_CAN ? lock_menu_pkg::MODE_SOLO
    : lock_menu_pkg::MODE_PROP; // RL12

  always_comb
  begin
    next_state = state;
    next_cand = cand;
    save = 1'b0;
    if (timeout)
      next_state = lock_menu_pkg::ST_ABORT; // RL18
    else
    begin
      case (state)
        lock_menu_pkg::ST_SHOW_MODE:
          if (tick && ph == 4'(`LOCK_SHOW_TICKS - 1)) // RL4
            next_state = cfg.mode == lock_menu_pkg::MODE_SOLO ? lock_menu_pkg::ST_IDLE
              : lock_menu_pkg::ST_SHOW_ADDR;
        lock_menu_pkg::ST_SHOW_ADDR:
          if (tick && ph == addrFlash) // RL5
            next_state = (cfg.mode == lock_menu_pkg::MODE_CAN && cfg.term)
              ? lock_menu_pkg::ST_SHOW_TERM : lock_menu_pkg::ST_IDLE; // RL6
        lock_menu_pkg::ST_SHOW_TERM:
          if (tick && ph == 4'(`LOCK_TERM_TICKS - 1))
            next_state = lock_menu_pkg::ST_IDLE; // RL6
        lock_menu_pkg::ST_IDLE:
          if (longEvt && allowed) // RL7 RL8
          begin
            next_state = lock_menu_pkg::ST_SEL_MODE;
            next_cand = cfg;
          end
        lock_menu_pkg::ST_SEL_MODE:
          if (handleEvt)
            next_cand.mode = modeStep; // RL12
          else if (briefEvt && cand.mode != lock_menu_pkg::MODE_SOLO)
            next_state = lock_menu_pkg::ST_SEL_ADDR; // RL9
          else if (longEvt && cand.mode == lock_menu_pkg::MODE_SOLO)
            save = 1'b1; // RL16
        lock_menu_pkg::ST_SEL_ADDR:
          if (handleEvt)
            next_cand.addr = addrStep; // RL10 RL2
          else if (briefEvt)
            next_state = cand.mode == lock_menu_pkg::MODE_CAN ? lock_menu_pkg::ST_SEL_TERM
              : lock_menu_pkg::ST_SEL_MODE; // RL14 RL17
          else if (longEvt)
            save = 1'b1; // RL8
        lock_menu_pkg::ST_SEL_TERM:
          if (handleEvt)
            next_cand.term = !cand.term; // RL14
          else if (briefEvt)
            next_state = lock_menu_pkg::ST_SEL_MODE; // RL17
          else if (longEvt)
            save = 1'b1; // RL8
        lock_menu_pkg::ST_SAVED, lock_menu_pkg::ST_ABORT:
          if (tick && ph == 4'(`LOCK_SHOW_TICKS - 1))
            next_state = lock_menu_pkg::ST_IDLE; // RL15 RL18
        default:
          next_state = lock_menu_pkg::ST_IDLE;
      endcase
      if (save)
        next_state = lock_menu_pkg::ST_SAVED; // RL15
    end
  end

  // the candidate lives in flops only; a power loss resets it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= lock_menu_pkg::ST_SHOW_MODE; // RL4
      cand <= '{lock_menu_pkg::mode_t'(`LOCK_DEF_MODE), `LOCK_DEF_ADDR, `LOCK_DEF_TERM}; // RL19
      cfg <= '{lock_menu_pkg::mode_t'(`LOCK_DEF_MODE), `LOCK_DEF_ADDR, `LOCK_DEF_TERM}; // RL3
      saveStrobe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cand <= next_cand;
      saveStrobe <= save;
      if (save)
        cfg <= next_cand; // RL15
      else if (cfgWrOk)
        cfg <= '{lock_menu_pkg::mode_t'(regWdata[`LOCK_CFG_MODE_LSB+:2]),
          regWdata[`LOCK_CFG_ADDR_LSB+:3], regWdata[`LOCK_CFG_TERM_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // led pattern

  wire logic restart;
  wire logic repeating;
  wire logic [3:0] period;
  lock_menu_pkg::led_t next_led;

  assign restart = next_state != state || (handleEvt && inMenu);
  assign repeating = inMenu;
  assign period = state == lock_menu_pkg::ST_SEL_MODE ? 4'h2
    : state == lock_menu_pkg::ST_SEL_ADDR ? {cand.addr, 1'b0} + 4'(`LOCK_SHOW_TICKS) // RL13
    : 4'h2 + 4'(`LOCK_SHOW_TICKS); // RL14

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ph <= '0;
    else if (restart)
      ph <= '0;
    else if (tick && repeating && ph == period - 4'h1)
      ph <= '0; // RL13 RL14
    else if (tick && ph != 4'hf)
      ph <= ph + 4'h1;
  end

  function automatic lock_menu_pkg::led_t modeColour(lock_menu_pkg::mode_t m);
    case (m)
      lock_menu_pkg::MODE_PROP: return lock_menu_pkg::LED_BLUE;
      lock_menu_pkg::MODE_CAN: return lock_menu_pkg::LED_YELLOW;
      lock_menu_pkg::MODE_SOLO: return lock_menu_pkg::LED_ORANGE;
      default: return lock_menu_pkg::LED_OFF;
    endcase
  endfunction

  always_comb
  begin
    next_led = lock_menu_pkg::LED_OFF;
    case (state)
      lock_menu_pkg::ST_SHOW_MODE, lock_menu_pkg::ST_IDLE:
        if (doorOpen)
          next_led = modeColour(cfg.mode); // RL1 RL4
      lock_menu_pkg::ST_SHOW_ADDR:
        if (doorOpen && !ph[0])
          next_led = lock_menu_pkg::LED_GREEN; // RL5
      lock_menu_pkg::ST_SHOW_TERM:
        if (doorOpen)
          next_led = lock_menu_pkg::LED_GREEN; // RL6
      lock_menu_pkg::ST_SEL_MODE:
        if (!ph[0])
          next_led = modeColour(cand.mode); // RL12
      lock_menu_pkg::ST_SEL_ADDR:
        if (!ph[0] && ph < {cand.addr, 1'b0})
          next_led = lock_menu_pkg::LED_GREEN; // RL13
      lock_menu_pkg::ST_SEL_TERM:
        if (ph == 4'h0)
          next_led = cand.term ? lock_menu_pkg::LED_GREEN : lock_menu_pkg::LED_RED; // RL14
      lock_menu_pkg::ST_SAVED:
        if (!ph[0])
          next_led = lock_menu_pkg::LED_GREEN; // RL15
      lock_menu_pkg::ST_ABORT:
        next_led = lock_menu_pkg::LED_RED; // RL18
      default:
        next_led = lock_menu_pkg::LED_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      led <= lock_menu_pkg::LED_OFF;
    else
      led <= next_led;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_addr_range: // RL2
    assert property (cfg.addr >= `LOCK_ADDR_MIN && cfg.addr <= `LOCK_ADDR_MAX
      && cand.addr >= `LOCK_ADDR_MIN && cand.addr <= `LOCK_ADDR_MAX)
    else $error("address out of range");

  a_idle_colour: // RL1
    assert property (state == lock_menu_pkg::ST_IDLE && doorOpen && $stable(cfg)
      |=> led == modeColour($past(cfg.mode)))
    else $error("idle led not mode colour");

  a_entry_gate: // RL7
    assert property ($rose(inMenu) |-> $past(allowed) && $past(longEvt)
      && $past(state) == lock_menu_pkg::ST_IDLE)
    else $error("menu entered without permission");

  a_save_stores: // RL15
    assert property (saveStrobe |-> cfg == $past(cand) && state == lock_menu_pkg::ST_SAVED
      ##1 (led == lock_menu_pkg::LED_GREEN) [*2])
    else $error("save did not store or show green");

  a_solo_no_addr: // RL16
    assert property (state == lock_menu_pkg::ST_SEL_MODE && cand.mode == lock_menu_pkg::MODE_SOLO
      |=> state != lock_menu_pkg::ST_SEL_ADDR)
    else $error("stand-alone entered address stage");

  a_addr_wrap: // RL10
    assert property (state == lock_menu_pkg::ST_SEL_ADDR && handleEvt && !timeout
      && cand.addr == `LOCK_ADDR_MAX |=> cand.addr == `LOCK_ADDR_MIN)
    else $error("address did not wrap");

  a_back_prop: // RL17
    assert property (state == lock_menu_pkg::ST_SEL_ADDR && briefEvt && !handleEvt && !timeout
      && cand.mode == lock_menu_pkg::MODE_PROP |=> state == lock_menu_pkg::ST_SEL_MODE)
    else $error("brief turn did not return to mode stage");

  a_abort_keeps: // RL18
    assert property (state == lock_menu_pkg::ST_ABORT && !$past(cfgWrOk)
      |-> cfg == $past(cfg) ##1 led == lock_menu_pkg::LED_RED)
    else $error("abort changed config or led not red");

  a_menu_bound: // RL18
    assert property (menuTicks <= 10'(`LOCK_MENU_TICKS))
    else $error("menu outlived its timeout");

endmodule // lock_parameter_menu_fsm

`default_nettype wire

// >>> bench/op_model.sv
// operator model: door contact, key cylinder switch and handle switch
`timescale 1ns/100ps
`default_nettype none
module op_model (
  input wire logic ref_clk, // bench clock
  output logic doorOpen, // door contact, high when open
  output logic keyUnlock, // key at unlock end stop
  output logic handleDown // handle pressed
);
  // door open and handle released before any start hold
  initial
  begin
    doorOpen = 1'b1;
    keyUnlock = 1'b0;
    handleDown = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // key held at the end stop for cyc clocks, then back to start position
  task automatic turn_key(input int cyc);
    begin
      @(posedge ref_clk);
      keyUnlock <= 1'b1;
      repeat (cyc) @(posedge ref_clk);
      keyUnlock <= 1'b0;
      repeat (24) @(posedge ref_clk);
    end
  endtask
  // brief handle press, long enough to pass the debounce
  task automatic press_handle;
    begin
      @(posedge ref_clk);
      handleDown <= 1'b1;
      repeat (24) @(posedge ref_clk);
      handleDown <= 1'b0;
      repeat (24) @(posedge ref_clk);
    end
  endtask
endmodule // op_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench of the lock parameter menu
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int TICK = 8;
  localparam int HOLD = 200;
  localparam int BRIEF = 40;
  // accepted flag beside CFG write data
  localparam logic [8:0] ROWS [7] = '{9'h000, 9'h112, 9'h014, 9'h007, 9'h104, 9'h10d, 9'h129};
  logic ref_clk, rstn, regWr, regRd, saveStrobe;
  logic doorOpen, keyUnlock, handleDown;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, rd;
  lock_menu_pkg::led_t led;
  lock_menu_pkg::cfg_t cfg, expCfg;
  lock_menu_pkg::led_t seq [3];
  int fails = 0;
  int num_checks = 0;
  int saves = 0;

  lock_parameter_menu_fsm #(.TICK_CYCLES(TICK), .DEB_CYCLES(2)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .doorOpen(doorOpen), .keyUnlock(keyUnlock),
    .handleDown(handleDown), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .led(led), .cfg(cfg), .saveStrobe(saveStrobe));
  op_model u_op (.ref_clk(ref_clk), .doorOpen(doorOpen), .keyUnlock(keyUnlock),
    .handleDown(handleDown));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (saveStrobe === 1'b1)
      saves++;
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  function automatic lock_menu_pkg::led_t colour(input lock_menu_pkg::mode_t m);
    colour = (m == lock_menu_pkg::MODE_PROP) ? lock_menu_pkg::LED_BLUE :
      (m == lock_menu_pkg::MODE_CAN) ? lock_menu_pkg::LED_YELLOW : lock_menu_pkg::LED_ORANGE;
  endfunction
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
    end
  endtask
  task automatic reg_rd(input logic [3:0] a);
    begin
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      rd = regRdata;
    end
  endtask
  task automatic stat(input logic [7:0] e);
    begin
      reg_rd(4'h8);
      check(rd & 8'h1f, e);
    end
  endtask
  // bounded wait for a colour on the led
  task automatic wait_led(input lock_menu_pkg::led_t c, input int lim);
    int n;
    begin
      n = 0;
      while (led !== c && n < lim)
      begin
        @(negedge ref_clk);
        n++;
      end
      check({5'h0, led}, {5'h0, c});
    end
  endtask
  // mode colour length, green cycles of address and termination, then idle
  task automatic powerup(input lock_menu_pkg::cfg_t c);
    int pre, grn, n;
    begin
      pre = 0;
      grn = 0;
      n = 0;
      while (led !== lock_menu_pkg::LED_GREEN && n < 200)
      begin
        if (led === colour(c.mode))
          pre++;
        @(negedge ref_clk);
        n++;
      end
      while (led !== colour(c.mode) && n < 400)
      begin
        if (led === lock_menu_pkg::LED_GREEN)
          grn++;
        @(negedge ref_clk);
        n++;
      end
      check({7'h0, pre >= 3 * TICK && pre <= 4 * TICK}, 8'h01);
      check(grn[7:0], 8'(TICK * (c.addr + 2 * c.term)));
      repeat (3 * TICK) @(negedge ref_clk);
      check({5'h0, led}, {5'h0, colour(c.mode)});
    end
  endtask
  task automatic do_reset;
    begin
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check({2'h0, cfg}, {2'h0, lock_menu_pkg::MODE_PROP, 3'h1, 1'b0});
      check({5'h0, led}, 8'h00);
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    seq = '{lock_menu_pkg::LED_ORANGE, lock_menu_pkg::LED_BLUE, lock_menu_pkg::LED_YELLOW};
    do_reset();
    powerup({lock_menu_pkg::MODE_PROP, 3'h1, 1'b0});
    stat(8'h03);
    do_reset();
    reg_wr(4'h0, 8'h29);
    powerup({lock_menu_pkg::MODE_CAN, 3'h2, 1'b1});
    reg_rd(4'h4);
    check(rd, 8'h00);
    reg_rd(4'hc);
    check(rd, 8'h00);
    // restore rows: refused writes leave the stored value alone
    expCfg = cfg;
    for (int i = 0; i < 7; i++)
    begin
      reg_wr(4'h0, ROWS[i][7:0]);
      if (ROWS[i][8])
        expCfg = {ROWS[i][1:0], ROWS[i][4:2], ROWS[i][5]};
      @(negedge ref_clk);
      check({2'h0, cfg}, {2'h0, expCfg});
      reg_rd(4'h0);
      check(rd, {2'h0, expCfg.term, expCfg.addr, expCfg.mode});
    end
    // entry refused while an error shows
    reg_wr(4'h4, 8'h03);
    u_op.turn_key(HOLD);
    stat(8'h03);
    reg_wr(4'h4, 8'h01);
    u_op.turn_key(HOLD);
    stat(8'h14);
    wait_led(lock_menu_pkg::LED_YELLOW, 4 * TICK);
    for (int i = 0; i < 3; i++)
    begin
      u_op.press_handle();
      wait_led(seq[i], 4 * TICK);
    end
    u_op.turn_key(BRIEF);
    stat(8'h15);
    wait_led(lock_menu_pkg::LED_GREEN, 8 * TICK);
    repeat (3) u_op.press_handle();
    u_op.turn_key(BRIEF);
    stat(8'h16);
    wait_led(lock_menu_pkg::LED_GREEN, 8 * TICK);
    u_op.press_handle();
    wait_led(lock_menu_pkg::LED_RED, 8 * TICK);
    u_op.turn_key(HOLD);
    check(saves[7:0], 8'h01);
    check({2'h0, cfg}, {2'h0, lock_menu_pkg::MODE_CAN, 3'h1, 1'b0});
    wait_led(lock_menu_pkg::LED_YELLOW, 8 * TICK);
    // return path through the termination stage in CAN mode, then stand-alone save
    u_op.turn_key(HOLD);
    u_op.turn_key(BRIEF);
    stat(8'h15);
    u_op.turn_key(BRIEF);
    u_op.turn_key(BRIEF);
    stat(8'h14);
    u_op.press_handle();
    wait_led(lock_menu_pkg::LED_ORANGE, 4 * TICK);
    u_op.turn_key(HOLD);
    check(saves[7:0], 8'h02);
    check({6'h0, cfg.mode}, {6'h0, lock_menu_pkg::MODE_SOLO});
    wait_led(lock_menu_pkg::LED_ORANGE, 8 * TICK);
    // timeout discards the pending candidate
    expCfg = cfg;
    u_op.turn_key(HOLD);
    reg_wr(4'h0, 8'h04);
    u_op.press_handle();
    // proprietary bus candidate: one brief turn returns to mode stage
    u_op.turn_key(BRIEF);
    stat(8'h15);
    u_op.turn_key(BRIEF);
    stat(8'h14);
    wait_led(lock_menu_pkg::LED_RED, 5000);
    stat(8'h08);
    wait_led(lock_menu_pkg::LED_ORANGE, 6 * TICK);
    check({2'h0, cfg}, {2'h0, expCfg});
    check(saves[7:0], 8'h02);
    // entry refused once the uptime window has closed
    repeat (14000) @(posedge ref_clk);
    u_op.turn_key(HOLD);
    stat(8'h03);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
